// ---- design/pin_sync.v ----
/*
 * Two-stage synchroniser bank for asynchronous comparator and strap pins.
 * Assumes one clock, a synchronous active-high reset and a clock enable.
 */
`default_nettype none

module pin_sync #(
  parameter W = 1
) (
  // Clock, reset and enable.
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire         ce_i,
  // Pins and their synchronised copies.
  input  wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // The first stage feeds only the second stage, never any logic.
  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else if (ce_i) begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule

`default_nettype wire

// ---- design/regulator_fault_sequencer.v ----
/*
 * Fault and protection sequencer of a synchronous buck regulator: lockout,
 * soft-start, overcurrent hiccup, thermal shutdown, power-good window and
 * latched over-voltage response, with a duty-limited PWM timebase.
 * Assumes digitised comparator results on asynchronous pins, a 50 MHz clock
 * and a classic Wishbone master.
 */
// Chosen here: the Wishbone register port and the register addresses.
//
// Contract
// - Enable below stop level tri-states both drivers.
// - Strap picks one of three current limits.
// - Sample current before valley, flag overcurrent event.
// - Overcurrent pulls power-good low, enters hiccup.
// - Hiccup latches flag, switches off for blanking.
// - Blanking end clears flag, restarts soft-start, repeats.
// - Thermal trip stops switches, resets soft-start.
// - Thermal release restarts through soft-start automatically.
// - Power-good high only inside sense window.
// - Power-good only pulls low; pull-up outside.
// - Over-voltage trips after qualification delay.
// - Over-voltage latches high side off, low side discharges.
// - Low side off once sense below threshold.
// - High side latched until enable or bias cycles.
// - Over-voltage armed only after enable start level.
// - High-side on-time capped at 86 percent.
// - Drivers off while bias or enable locked out.
// - Soft-start begins only on power-on-ready.
// - Overcurrent and over-voltage armed during soft-start.
`default_nettype none
`include "fault_seq_regs.vh"

module regulator_fault_sequencer #(
  parameter [19:0] BLANK_CYCLES = `BLANK_CYC
) (
  // Clock, reset and enable.
  input  wire        CLOCK_I,
  input  wire        RST_I,
  input  wire        CE_I,
  // Wishbone slave.
  input  wire [3:0]  ADR_I,
  input  wire [31:0] DAT_I,
  input  wire [3:0]  SEL_I,
  input  wire        WE_I,
  input  wire        CYC_I,
  input  wire        STB_I,
  output reg  [31:0] DAT_O,
  output reg         ACK_O,
  // Comparator and strap pins.
  input  wire        BIAS_OK_I,
  input  wire        ENABLE_RUN_I,
  input  wire        ENABLE_START_I,
  input  wire        THERMAL_TRIP_I,
  input  wire        SENSE_ABOVE_LOW_I,
  input  wire        SENSE_ABOVE_HIGH_I,
  input  wire        LIMIT_STRAP_HIGH_I,
  input  wire        LIMIT_STRAP_LOW_I,
  input  wire [7:0]  LOW_SIDE_CURRENT_I,
  // Gate drivers.
  output reg         HS_GATE_O,
  output reg         HS_OE_N_O,
  output reg         LS_GATE_O,
  output reg         LS_OE_N_O,
  // Open-drain power-good pin.
  input  wire        POWER_GOOD_I,
  output reg         POWER_GOOD_O,
  output reg         POWER_GOOD_OE_N_O
);

  localparam [2:0] ST_OFF    = 3'h0;
  localparam [2:0] ST_SOFT   = 3'h1;
  localparam [2:0] ST_RUN    = 3'h2;
  localparam [2:0] ST_HICCUP = 3'h3;
  localparam [2:0] ST_THERM  = 3'h4;
  localparam [2:0] ST_OVP    = 3'h5;
  localparam integer SAMPLE_N = `SAMPLE_WIN_CYC, OVP_N = `OVP_DELAY_CYC, SS_N = `SS_STEP_CYC;
  localparam integer STRAP_N  = `STRAP_SETTLE_CYC;
  localparam [8:0]  SAMPLE_CYC = SAMPLE_N[8:0];
  localparam [6:0]  OVP_CYC    = OVP_N[6:0];
  localparam [9:0]  SS_STEP    = SS_N[9:0];
  localparam [1:0]  STRAP_CYC  = STRAP_N[1:0];

  function hit;
    input [3:0] adr;
    input [3:0] ofs;
    begin
      hit = (adr[3:2] == ofs[3:2]);
    end
  endfunction
  function [7:0] duty_cap;
    input [7:0] period;
    reg   [15:0] prod;
    reg   [15:0] quot;
    begin
      prod     = {8'h00, period} * `DUTY_MAX_PCT;
      quot     = prod / `PCT_FULL;
      duty_cap = quot[7:0];
    end
  endfunction
  function [7:0] min8;
    input [7:0] a;
    input [7:0] b;
    begin
      min8 = (a < b) ? a : b;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  wire [16:0] pins_s;
  pin_sync #(
    .W (17)
  ) u_sync (
    .clk_i   (CLOCK_I),
    .rst_i   (RST_I),
    .ce_i    (CE_I),
    .async_i ({POWER_GOOD_I, LIMIT_STRAP_LOW_I, LIMIT_STRAP_HIGH_I,
               SENSE_ABOVE_HIGH_I, SENSE_ABOVE_LOW_I, THERMAL_TRIP_I,
               ENABLE_START_I, ENABLE_RUN_I, BIAS_OK_I, LOW_SIDE_CURRENT_I}),
    .sync_o  (pins_s)
  );

  wire [7:0] cur_s    = pins_s[7:0];
  wire       bias_s   = pins_s[8];
  wire       en_run_s = pins_s[9];
  wire       en_go_s  = pins_s[10];
  wire       therm_s  = pins_s[11];
  wire       win_lo_s = pins_s[12];
  wire       win_hi_s = pins_s[13];
  wire       str_hi_s = pins_s[14];
  wire       str_lo_s = pins_s[15];
  wire       pg_pin_s = pins_s[16];

  ////////////////////////////////////////////////////////////////////////////
  // State.

  reg [2:0]  state_q;
  reg [2:0]  state_d;
  reg [7:0]  period_q;
  reg [7:0]  demand_q;
  reg [7:0]  cnt_q;
  reg [7:0]  ramp_q;
  reg [9:0]  step_q;
  reg [19:0] blank_q;
  reg [6:0]  ovp_cnt_q;
  reg        oc_flag_q;
  reg        ls_ok_q;
  reg [1:0]  limit_q;
  reg [1:0]  strap_cnt_q;
  reg [2:0]  events_q;
  wire lockout  = !bias_s || !en_run_s;
  wire por      = bias_s && en_go_s;
  wire active   = (state_q == ST_SOFT) || (state_q == ST_RUN);
  // Comparator is armed only in states reached through the start threshold.
  wire ovp_arm  = (state_q != ST_OFF) && (state_q != ST_OVP);
  wire ovp_trip = ovp_arm && win_hi_s && (ovp_cnt_q == OVP_CYC - 7'h01);
  wire blank_end = (blank_q == BLANK_CYCLES - 20'h00001);
  // Current is sampled ahead of the valley by an eighth of the period.
  wire [7:0] win_start = period_q - {3'b000, period_q[7:3]};
  wire       in_sample = (cnt_q >= win_start) &&
                         ({1'b0, cnt_q} < {1'b0, win_start} + SAMPLE_CYC);
  wire [7:0] limit_lvl = (limit_q == `LIMIT_LOW)  ? `LIMIT_LOW_LEVEL :
                         (limit_q == `LIMIT_HIGH) ? `LIMIT_HIGH_LEVEL :
                                                    `LIMIT_MID_LEVEL;
  wire oc_event = active && LS_GATE_O && in_sample && (cur_s > limit_lvl);

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_OFF: begin
        if (!lockout && por) begin
          state_d = ST_SOFT;
        end
      end
      ST_SOFT: begin
        if (ramp_q == 8'hff) begin
          state_d = ST_RUN;
        end
      end
      ST_HICCUP: begin
        if (blank_end) begin
          state_d = ST_SOFT;
        end
      end
      ST_THERM: begin
        if (!therm_s) begin
          state_d = ST_SOFT;
        end
      end
      ST_RUN, ST_OVP: begin
        state_d = state_q;
      end
      default: begin
        state_d = ST_OFF;
      end
    endcase
    if (state_q != ST_OFF && lockout) begin
      state_d = ST_OFF;
    end else if (ovp_trip) begin
      state_d = ST_OVP;
    end else if (therm_s && ovp_arm && state_q != ST_THERM) begin
      state_d = ST_THERM;
    end else if (oc_event) begin
      state_d = ST_HICCUP;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer, timebase and protection counters.

  wire       run_d   = (state_d == ST_SOFT) || (state_d == ST_RUN);
  wire [7:0] on_lim  = min8(demand_q, duty_cap(period_q));
  wire [7:0] on_time = (state_d == ST_SOFT) ? min8(on_lim, ramp_q) : on_lim;
  wire       hs_d    = run_d && (cnt_q < on_time);
  // Sync FET waits for the first control pulse so a pre-biased output is kept.
  wire       ls_d    = (run_d && !hs_d && ls_ok_q) ||
                       ((state_d == ST_OVP) && win_hi_s && !therm_s);
  wire       pg_d    = win_lo_s && !win_hi_s &&
                       (state_d != ST_HICCUP) && (state_d != ST_OVP);

  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      state_q     <= ST_OFF;
      cnt_q       <= 8'h00;
      ramp_q      <= 8'h00;
      step_q      <= 10'h000;
      blank_q     <= 20'h00000;
      ovp_cnt_q   <= 7'h00;
      oc_flag_q   <= 1'b0;
      ls_ok_q     <= 1'b0;
      limit_q     <= `LIMIT_MID;
      strap_cnt_q <= 2'h0;
    end else if (CE_I) begin
      state_q <= state_d;
      cnt_q   <= (cnt_q >= period_q - 8'h01) ? 8'h00 : cnt_q + 8'h01;
      // Strap is read once, after the synchronisers have settled.
      if (strap_cnt_q != STRAP_CYC) begin
        strap_cnt_q <= strap_cnt_q + 2'h1;
        if (strap_cnt_q == STRAP_CYC - 2'h1) begin
          limit_q <= str_hi_s ? `LIMIT_HIGH :
                     str_lo_s ? `LIMIT_LOW : `LIMIT_MID;
        end
      end
      if (state_q == ST_SOFT) begin
        if (step_q == SS_STEP - 10'h001) begin
          step_q <= 10'h000;
          ramp_q <= ramp_q + 8'h01;
        end else begin
          step_q <= step_q + 10'h001;
        end
      end else if (state_q != ST_RUN) begin
        step_q <= 10'h000;
        ramp_q <= 8'h00;
      end
      blank_q <= (state_q == ST_HICCUP) ? blank_q + 20'h00001 : 20'h00000;
      if (oc_event) begin
        oc_flag_q <= 1'b1;
      end else if (state_q == ST_HICCUP && blank_end) begin
        oc_flag_q <= 1'b0;
      end
      if (ovp_arm && win_hi_s && ovp_cnt_q != OVP_CYC - 7'h01) begin
        ovp_cnt_q <= ovp_cnt_q + 7'h01;
      end else if (!win_hi_s || !ovp_arm) begin
        ovp_cnt_q <= 7'h00;
      end
      if (!run_d) begin
        ls_ok_q <= 1'b0;
      end else if (HS_GATE_O) begin
        ls_ok_q <= 1'b1;
      end
    end
  end

  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      HS_GATE_O         <= 1'b0;
      LS_GATE_O         <= 1'b0;
      HS_OE_N_O         <= 1'b1;
      LS_OE_N_O         <= 1'b1;
      POWER_GOOD_O      <= 1'b0;
      POWER_GOOD_OE_N_O <= 1'b0;
    end else if (CE_I) begin
      HS_GATE_O         <= hs_d;
      LS_GATE_O         <= ls_d;
      HS_OE_N_O         <= (state_d == ST_OFF);
      LS_OE_N_O         <= (state_d == ST_OFF);
      POWER_GOOD_O      <= 1'b0;
      POWER_GOOD_OE_N_O <= pg_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone registers.

  wire req    = CYC_I && STB_I && !ACK_O;
  wire wr     = req && WE_I;
  wire ev_clr = wr && hit(ADR_I, `OFS_EVENTS) && SEL_I[0];
  wire [2:0] ev_set = {state_d == ST_THERM && state_q != ST_THERM,
                       ovp_trip, oc_event};

  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      period_q <= `PWM_PERIOD_RST;
      demand_q <= `PWM_DEMAND_RST;
      events_q <= 3'h0;
      ACK_O    <= 1'b0;
      DAT_O    <= 32'h00000000;
    end else if (CE_I) begin
      ACK_O <= req;
      // A new event wins over a clear in the same cycle.
      events_q <= (ev_clr ? events_q & ~DAT_I[2:0] : events_q) | ev_set;
      if (wr && hit(ADR_I, `OFS_PWM_CFG)) begin
        if (SEL_I[0]) begin
          period_q <= DAT_I[`PWM_PERIOD_LSB +: 8];
        end
        if (SEL_I[1]) begin
          demand_q <= DAT_I[`PWM_DEMAND_LSB +: 8];
        end
      end
      if (req && !WE_I) begin
        DAT_O <= 32'h00000000;
        if (hit(ADR_I, `OFS_PWM_CFG)) begin
          DAT_O <= {16'h0000, demand_q, period_q};
        end else if (hit(ADR_I, `OFS_STATUS)) begin
          DAT_O <= {22'h000000, limit_q, 1'b0, pg_pin_s, therm_s,
                    state_q == ST_OVP, oc_flag_q, state_q};
        end else if (hit(ADR_I, `OFS_EVENTS)) begin
          DAT_O <= {29'h00000000, events_q};
        end
      end
    end
  end

endmodule

`default_nettype wire

// ---- pkg/fault_seq_regs.vh ----
/*
 * Constants of the regulator fault sequencer: register offsets, field
 * positions, reset values and timing counts at a 50 MHz clock.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef FAULT_SEQ_REGS_VH
`define FAULT_SEQ_REGS_VH

// Register byte offsets on the Wishbone bus.
`define OFS_PWM_CFG       4'h0
`define OFS_STATUS        4'h4
`define OFS_EVENTS        4'h8

// Switching configuration fields and reset values.
`define PWM_PERIOD_LSB    0
`define PWM_DEMAND_LSB    8
`define PWM_PERIOD_RST    8'h53
`define PWM_DEMAND_RST    8'h00

// Status fields.
`define ST_STATE_LSB      0
`define ST_OC_FLAG_BIT    3
`define ST_OVP_BIT        4
`define ST_THERM_BIT      5
`define ST_POWER_GOOD_BIT      6
`define ST_LIMIT_LSB      8

// Sticky event bits, cleared by writing one.
`define EV_OC_BIT         0
`define EV_OVP_BIT        1
`define EV_THERM_BIT      2

// Current limit codes picked by the strap, and their trip levels.
`define LIMIT_LOW         2'h0
`define LIMIT_MID         2'h1
`define LIMIT_HIGH        2'h2
`define LIMIT_LOW_LEVEL   8'h40
`define LIMIT_MID_LEVEL   8'h60
`define LIMIT_HIGH_LEVEL  8'h80

// Timing, each time in its own unit and the cycle count derived from it.
`define CLK_FREQ_MHZ      50
`define SAMPLE_WIN_NS     40
`define SAMPLE_WIN_CYC    ((`SAMPLE_WIN_NS * `CLK_FREQ_MHZ + 999) / 1000)
`define OVP_DELAY_NS      2000
`define OVP_DELAY_CYC     ((`OVP_DELAY_NS * `CLK_FREQ_MHZ) / 1000)
`define BLANK_TIME_US     20480
`define BLANK_CYC         (`BLANK_TIME_US * `CLK_FREQ_MHZ)
`define SS_TIME_US        3000
`define SS_STEP_CYC       ((`SS_TIME_US * `CLK_FREQ_MHZ) / 256)
`define STRAP_SETTLE_CYC  3

// Duty ratio ceiling in percent.
`define DUTY_MAX_PCT      16'd86
`define PCT_FULL          16'd100

`endif

// ---- tb/power_stage_model.sv ----
/* Far side of the sequencer: output-sense comparators and the board pull-up.
   Assumes the bench gives the output level in percent of the reference. */
`default_nettype none
module power_stage_model (
  // Output level and comparator results.
  input  wire logic [7:0] sense_pct_i,
  output wire logic       above_low_o,
  output wire logic       above_high_o,
  // Open-drain power-good pin.
  input  wire logic       pg_drive_i,
  input  wire logic       pg_oe_n_i,
  output wire logic       pg_pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  assign above_low_o  = sense_pct_i > 8'd85;
  assign above_high_o = sense_pct_i > 8'd120;
  // Released pin floats up through the pull-up.
  assign pg_pin_o = pg_oe_n_i ? 1'b1 : pg_drive_i;
endmodule
`default_nettype wire

// ---- tb/regulator_fault_sequencer_monitor.sv ----
/* Pin-level checks on the fault sequencer's drivers and power-good output.
   Assumes every pin passes a two-flop synchroniser and a registered output. */
`default_nettype none
module fault_seq_monitor (
  // Clock and pins.
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  input wire logic BIAS_OK_I,
  input wire logic ENABLE_RUN_I,
  input wire logic ENABLE_START_I,
  input wire logic THERMAL_TRIP_I,
  input wire logic SENSE_ABOVE_LOW_I,
  input wire logic SENSE_ABOVE_HIGH_I,
  // Drivers.
  input wire logic HS_GATE_O,
  input wire logic LS_GATE_O,
  input wire logic HS_OE_N_O,
  input wire logic LS_OE_N_O,
  input wire logic POWER_GOOD_O,
  input wire logic POWER_GOOD_OE_N_O
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] hi_cnt_q;
  logic       trip_q;
  logic       armed;
  assign armed = CE_I && SENSE_ABOVE_HIGH_I && ENABLE_START_I && ENABLE_RUN_I && BIAS_OK_I;
  // The 120-cycle limit leaves 20 cycles for synchroniser and state latency beyond the 100-cycle delay.
  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      hi_cnt_q <= 8'h00;
      trip_q   <= 1'b0;
    end else begin
      hi_cnt_q <= armed ? hi_cnt_q + {7'h00, hi_cnt_q != 8'hff} : 8'h00;
      trip_q   <= (trip_q || hi_cnt_q > 8'd120) && ENABLE_RUN_I && BIAS_OK_I;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking dc @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  sequence s_run_low;
    (CE_I && !ENABLE_RUN_I) [*3];
  endsequence
  sequence s_hot;
    (CE_I && THERMAL_TRIP_I) [*3];
  endsequence
  a_run_lockout: assert property (s_run_low |=> HS_OE_N_O && LS_OE_N_O)
    else $error("drivers not tri-stated");
  a_bias_lockout: assert property ((CE_I && !BIAS_OK_I) [*3] |=> !HS_GATE_O && !LS_GATE_O)
    else $error("gates on during bias lockout");
  a_thermal_off: assert property (s_hot |=> !HS_GATE_O && !LS_GATE_O)
    else $error("gates on while hot");
  a_pg_window: assert property (POWER_GOOD_OE_N_O |->
    $past(SENSE_ABOVE_LOW_I, 3) && !$past(SENSE_ABOVE_HIGH_I, 3))
    else $error("power good released outside window");
  a_pg_open: assert property (POWER_GOOD_O == 1'b0)
    else $error("power good driven high");
  a_overvolt_trip: assert property (hi_cnt_q > 8'd120 |-> !HS_GATE_O && !POWER_GOOD_OE_N_O)
    else $error("no trip after delay");
  a_overvolt_latch: assert property (trip_q |-> !HS_GATE_O)
    else $error("high side on after trip");
  a_overvolt_sink: assert property ((trip_q && SENSE_ABOVE_HIGH_I) [*4] |-> LS_GATE_O)
    else $error("low side not discharging");
  a_overvolt_drain: assert property ((trip_q && !SENSE_ABOVE_HIGH_I) [*4] |-> !LS_GATE_O)
    else $error("low side still on");
endmodule
bind regulator_fault_sequencer fault_seq_monitor fault_seq_monitor_inst (
  .CLOCK_I(CLOCK_I), .RST_I(RST_I), .CE_I(CE_I), .BIAS_OK_I(BIAS_OK_I),
  .ENABLE_RUN_I(ENABLE_RUN_I), .ENABLE_START_I(ENABLE_START_I),
  .THERMAL_TRIP_I(THERMAL_TRIP_I), .SENSE_ABOVE_LOW_I(SENSE_ABOVE_LOW_I),
  .SENSE_ABOVE_HIGH_I(SENSE_ABOVE_HIGH_I), .HS_GATE_O(HS_GATE_O), .LS_GATE_O(LS_GATE_O),
  .HS_OE_N_O(HS_OE_N_O), .LS_OE_N_O(LS_OE_N_O), .POWER_GOOD_O(POWER_GOOD_O),
  .POWER_GOOD_OE_N_O(POWER_GOOD_OE_N_O)
);
`default_nettype wire

// ---- tb/tb_regulator_fault_sequencer.sv ----
/* Self-checking bench of the fault sequencer: straps, bus, start-up, duty cap,
   power-good and the fault responses. Assumes a short blanking count. */
`default_nettype none
`include "fault_seq_regs.vh"
module tb_regulator_fault_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CLOCK_I, RST_I, CE_I, WE_I, CYC_I, STB_I, ACK_O, POWER_GOOD_I, POWER_GOOD_O;
  logic        BIAS_OK_I, ENABLE_RUN_I, ENABLE_START_I, THERMAL_TRIP_I, LIMIT_STRAP_HIGH_I;
  logic        LIMIT_STRAP_LOW_I, SENSE_ABOVE_LOW_I, SENSE_ABOVE_HIGH_I, POWER_GOOD_OE_N_O;
  logic        HS_GATE_O, HS_OE_N_O, LS_GATE_O, LS_OE_N_O;
  logic [3:0]  ADR_I, SEL_I;
  logic [31:0] DAT_I, DAT_O, q;
  logic [7:0]  LOW_SIDE_CURRENT_I, pct;
  int          error_cnt, n_compared, n, mx, run;
  typedef struct packed { logic hi; logic lo; logic [1:0] lim; } strap_t;
  strap_t rows [3] = '{'{1'b0, 1'b0, `LIMIT_MID}, '{1'b1, 1'b0, `LIMIT_HIGH},
                       '{1'b0, 1'b1, `LIMIT_LOW}};
  regulator_fault_sequencer #(.BLANK_CYCLES(20'h000c8)) regulator_fault_sequencer_inst (.*);
  power_stage_model power_stage_model_inst (.sense_pct_i(pct), .above_low_o(SENSE_ABOVE_LOW_I),
    .above_high_o(SENSE_ABOVE_HIGH_I), .pg_drive_i(POWER_GOOD_O),
    .pg_oe_n_i(POWER_GOOD_OE_N_O), .pg_pin_o(POWER_GOOD_I));
  always #10 CLOCK_I = ~CLOCK_I;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Request held until ack is sampled; one idle cycle follows every access.
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    CYC_I <= 1'b1;
    STB_I <= 1'b1;
    WE_I <= we;
    ADR_I <= a;
    DAT_I <= d;
    do begin
      @(posedge CLOCK_I);
      k++;
    end while (ACK_O !== 1'b1 && k < 20);
    q = DAT_O;
    CYC_I <= 1'b0;
    STB_I <= 1'b0;
    @(posedge CLOCK_I);
    if (k >= 20) begin
      chk("ack", 1, 0);
      wrap_up();
    end
  endtask
  // Each poll costs three cycles, so n also measures elapsed time.
  task automatic wait_state(input logic [2:0] st);
    n = 0;
    do begin
      wb(1'b0, `OFS_STATUS, 32'h0);
      n++;
    end while (q[2:0] !== st && n < 400);
    chk("state", st, q[2:0]);
    if (n >= 400) wrap_up();
  endtask
  task automatic do_reset();
    RST_I <= 1'b1;
    repeat (5) @(posedge CLOCK_I);
    RST_I <= 1'b0;
    repeat (6) @(posedge CLOCK_I);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    CLOCK_I = 1'b0;
    CE_I = 1'b1;
    SEL_I = 4'hf;
    {WE_I, CYC_I, STB_I, ADR_I, DAT_I} = '0;
    {BIAS_OK_I, ENABLE_RUN_I, ENABLE_START_I, THERMAL_TRIP_I} = 4'h0;
    LOW_SIDE_CURRENT_I = 8'h00;
    pct = 8'd100;
    error_cnt = 0;
    n_compared = 0;
    foreach (rows[i]) begin
      LIMIT_STRAP_HIGH_I <= rows[i].hi;
      LIMIT_STRAP_LOW_I <= rows[i].lo;
      do_reset();
      wb(1'b0, `OFS_STATUS, 32'h0);
      chk("limit", rows[i].lim, q[`ST_LIMIT_LSB +: 2]);
    end
    chk("idle pins", 5'h19, {HS_OE_N_O, LS_OE_N_O, HS_GATE_O, LS_GATE_O, POWER_GOOD_OE_N_O});
    wb(1'b0, `OFS_PWM_CFG, 32'h0);
    chk("cfg", {`PWM_DEMAND_RST, `PWM_PERIOD_RST}, q);
    wb(1'b1, 4'hc, 32'hffffffff);
    wb(1'b0, 4'hc, 32'h0);
    chk("unmapped", 32'h0, q);
    BIAS_OK_I <= 1'b1;
    ENABLE_RUN_I <= 1'b1;
    pct <= 8'd130;
    repeat (150) @(posedge CLOCK_I);
    wait_state(3'h0);
    chk("hs idle", 1'b0, HS_GATE_O);
    pct <= 8'd100;
    wb(1'b1, `OFS_PWM_CFG, 32'h0000ff08);
    ENABLE_START_I <= 1'b1;
    n = 0;
    while (HS_GATE_O !== 1'b1 && n < 5000) begin
      @(posedge CLOCK_I);
      n++;
    end
    chk("hs start", 1, n < 5000);
    if (n >= 5000) wrap_up();
    chk("pg good", 1'b1, POWER_GOOD_I);
    pct <= 8'd80;
    repeat (5) @(posedge CLOCK_I);
    chk("pg low", 1'b0, POWER_GOOD_I);
    pct <= 8'd100;
    repeat (5000) @(posedge CLOCK_I);
    mx = 0;
    run = 0;
    repeat (400) begin
      @(posedge CLOCK_I);
      run = HS_GATE_O ? run + 1 : 0;
      mx = run > mx ? run : mx;
    end
    chk("on time", 8 * `DUTY_MAX_PCT / `PCT_FULL, mx);
    LOW_SIDE_CURRENT_I <= 8'hff;
    wait_state(3'h3);
    LOW_SIDE_CURRENT_I <= 8'h00;
    chk("flag", 1'b1, q[`ST_OC_FLAG_BIT]);
    chk("pg hiccup", 1'b0, POWER_GOOD_I);
    wait_state(3'h1);
    chk("blanking", 1, 3 * n >= 190 && 3 * n <= 210);
    chk("flag clear", 1'b0, q[`ST_OC_FLAG_BIT]);
    wb(1'b0, `OFS_EVENTS, 32'h0);
    chk("event", 1'b1, q[`EV_OC_BIT]);
    wb(1'b1, `OFS_EVENTS, 32'h1);
    wb(1'b0, `OFS_EVENTS, 32'h0);
    chk("event clear", 1'b0, q[`EV_OC_BIT]);
    THERMAL_TRIP_I <= 1'b1;
    wait_state(3'h4);
    chk("hot gates", 2'h0, {HS_GATE_O, LS_GATE_O});
    THERMAL_TRIP_I <= 1'b0;
    wait_state(3'h1);
    pct <= 8'd130;
    wait_state(3'h5);
    chk("trip delay", 1, 3 * n >= 99 && 3 * n <= 120);
    repeat (30) @(posedge CLOCK_I);
    chk("discharge", 2'h1, {HS_GATE_O, LS_GATE_O});
    chk("pg trip", 1'b0, POWER_GOOD_I);
    pct <= 8'd100;
    repeat (5) @(posedge CLOCK_I);
    chk("ls off", 1'b0, LS_GATE_O);
    repeat (100) @(posedge CLOCK_I);
    wait_state(3'h5);
    ENABLE_RUN_I <= 1'b0;
    repeat (5) @(posedge CLOCK_I);
    chk("tristate", 2'h3, {HS_OE_N_O, LS_OE_N_O});
    ENABLE_RUN_I <= 1'b1;
    wait_state(3'h1);
    wrap_up();
  end
endmodule
`default_nettype wire
